// ### src/rlst_seq.sv
// rlst_seq: reset output control with latch mode and one-shot built-in check.
// assumes comparator results arrive as asynchronous levels; all are synchronised.
`timescale 1ns/10ps
module rlst_seq #(
  parameter int unsigned CHECK_CYC    = rlst_pkg::CHECK_CYCLES,
  parameter int unsigned RECOVERY_CYC = rlst_pkg::RECOVERY_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic supply_ok_i,
  input  wire logic manual_reset_in_n_i,
  input  wire logic delay_pin_low_i,
  input  wire logic delay_pin_above_th_i,
  input  wire logic in_window_i,
  input  wire logic ov_detect_i,
  input  wire logic uv_detect_i,
  output logic      reset_o,
  output logic      check_force_ov_o,
  output logic      check_force_uv_o,
  output logic      check_busy_o,
  output logic      check_fail_o,
  output logic      latched_o
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 7;
  // reset levels equal the idle pins: a manual input resting high
  // must not look like a release once reset lets go
  localparam logic [NS-1:0] SYNC_RST = 7'h20;
  logic [NS-1:0] in_raw;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  assign in_raw = {supply_ok_i,
                   manual_reset_in_n_i,
                   delay_pin_low_i,
                   delay_pin_above_th_i,
                   in_window_i,
                   ov_detect_i,
                   uv_detect_i};
  // only the second stage is read by any logic
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end else begin
      s1_r <= in_raw;
      s2_r <= s1_r;
    end
  end

  // ----------------------------------------------------------------
  // synchronised levels
  // ----------------------------------------------------------------
  wire supply_ok = s2_r[6];
  wire mr_high   = s2_r[5];
  wire ct_low    = s2_r[4];
  wire ct_above  = s2_r[3];
  wire win_ok    = s2_r[2];
  wire ov_seen   = s2_r[1];
  wire uv_seen   = s2_r[0];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  rlst_pkg::rlst_state_t      state_r;
  rlst_pkg::rlst_state_t      state_nxt;
  logic [rlst_pkg::CNT_W-1:0] cnt_r;
  logic [rlst_pkg::CNT_W-1:0] cnt_nxt;
  logic                       mr_q_r;
  logic                       ov_ok_r;
  logic                       ov_ok_nxt;
  logic                       uv_ok_r;
  logic                       uv_ok_nxt;
  // check split in halves: first forces overvoltage, second undervoltage
  localparam logic [rlst_pkg::CNT_W-1:0] CHK_END  = rlst_pkg::CNT_W'(CHECK_CYC - 1);
  localparam logic [rlst_pkg::CNT_W-1:0] CHK_HALF = rlst_pkg::CNT_W'(CHECK_CYC / 2);
  localparam logic [rlst_pkg::CNT_W-1:0] DLY_END  =
    rlst_pkg::CNT_W'((RECOVERY_CYC > 0) ? RECOVERY_CYC - 1 : 0);

  // ----------------------------------------------------------------
  // trigger and check decode
  // ----------------------------------------------------------------
  wire mr_release  = mr_high && !mr_q_r;
  wire in_ov_half  = (state_r == rlst_pkg::RLST_CHECK) && (cnt_r < CHK_HALF);
  wire in_uv_half  = (state_r == rlst_pkg::RLST_CHECK) && (cnt_r >= CHK_HALF);
  wire check_pass  = ov_ok_r && uv_ok_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    ov_ok_nxt = ov_ok_r;
    uv_ok_nxt = uv_ok_r;
    if (!supply_ok) begin
      state_nxt = rlst_pkg::RLST_OFF;
      cnt_nxt   = '0;
    end else begin
      case (state_r)
        rlst_pkg::RLST_OFF: begin
          state_nxt = rlst_pkg::RLST_CHECK;
          cnt_nxt   = '0;
          ov_ok_nxt = 1'b0;
          uv_ok_nxt = 1'b0;
        end
        rlst_pkg::RLST_CHECK: begin
          if (in_ov_half && ov_seen) ov_ok_nxt = 1'b1;
          if (in_uv_half && uv_seen) uv_ok_nxt = 1'b1;
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CHK_END) begin
            cnt_nxt = '0;
            if (!check_pass) state_nxt = rlst_pkg::RLST_FAIL;
            else if (ct_low) state_nxt = rlst_pkg::RLST_LATCH;
            else state_nxt = rlst_pkg::RLST_DELAY;
          end
        end
        rlst_pkg::RLST_DELAY: begin
          // delay only counts while input high and voltage in window
          if (!mr_high || !win_ok) cnt_nxt = '0;
          else if (cnt_r == DLY_END) state_nxt = rlst_pkg::RLST_RUN;
          else cnt_nxt = cnt_r + 1'b1;
        end
        rlst_pkg::RLST_LATCH: begin
          // no recovery delay on unlatch
          if (ct_above && mr_high) state_nxt = rlst_pkg::RLST_RUN;
        end
        rlst_pkg::RLST_RUN: begin
          if (!mr_high) state_nxt = rlst_pkg::RLST_DELAY;
          else if (!win_ok) state_nxt = ct_low ? rlst_pkg::RLST_LATCH
                                               : rlst_pkg::RLST_DELAY;
          cnt_nxt = '0;
        end
        default: begin
          // failed check holds reset; only a new trigger retries
          cnt_nxt = '0;
        end
      endcase
      // a release after manual assertion reruns the check once
      if (mr_release && state_r != rlst_pkg::RLST_OFF) begin
        state_nxt = rlst_pkg::RLST_CHECK;
        cnt_nxt   = '0;
        ov_ok_nxt = 1'b0;
        uv_ok_nxt = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output decode
  // ----------------------------------------------------------------
  wire reset_nxt   = (state_nxt != rlst_pkg::RLST_RUN);
  wire force_ov    = (state_nxt == rlst_pkg::RLST_CHECK) && (cnt_nxt < CHK_HALF);
  wire force_uv    = (state_nxt == rlst_pkg::RLST_CHECK) && (cnt_nxt >= CHK_HALF);
  wire busy_nxt    = (state_nxt == rlst_pkg::RLST_CHECK);
  wire fail_nxt    = (state_nxt == rlst_pkg::RLST_FAIL);
  wire latched_nxt = (state_nxt == rlst_pkg::RLST_LATCH);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // one counter serves both the check and the recovery delay
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r <= rlst_pkg::RLST_OFF;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // results cleared at each check start, kept until the next one
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ov_ok_r <= 1'b0;
      uv_ok_r <= 1'b0;
    end else begin
      ov_ok_r <= ov_ok_nxt;
      uv_ok_r <= uv_ok_nxt;
    end
  end

  // previous synced level; idles high like the pin itself
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mr_q_r <= 1'b1;
    end else begin
      mr_q_r <= mr_high;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reset_o          <= 1'b1;
      check_force_ov_o <= 1'b0;
      check_force_uv_o <= 1'b0;
      check_busy_o     <= 1'b0;
      check_fail_o     <= 1'b0;
      latched_o        <= 1'b0;
    end else begin
      reset_o          <= reset_nxt;
      check_force_ov_o <= force_ov;
      check_force_uv_o <= force_uv;
      check_busy_o     <= busy_nxt;
      check_fail_o     <= fail_nxt;
      latched_o        <= latched_nxt;
    end
  end
endmodule // rlst_seq

// ### src/rlst_pkg.sv
// rlst_pkg: constants for the reset latch and self-test sequencer.
// assumes a 40 MHz clock; analog comparators are outside, seen as digital levels.
package rlst_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ             = 40000000;
  localparam int unsigned CHECK_DURATION_US  = 1000;
  localparam int unsigned CHECK_CYCLES       = (CHECK_DURATION_US * (CLK_HZ / 1000000));
  localparam int unsigned RECOVERY_DELAY_US  = 50;
  localparam int unsigned RECOVERY_CYCLES    = (RECOVERY_DELAY_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W              = 16;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RLST_OFF,
    RLST_CHECK,
    RLST_DELAY,
    RLST_RUN,
    RLST_LATCH,
    RLST_FAIL
  } rlst_state_t;
endpackage : rlst_pkg

// ### dv/rlst_seq_properties.sv
// rlst_seq_properties: port assertions for rlst_seq
// assumes the bind below hands on the shortened sim counts
`timescale 1ns/10ps
module rlst_seq_properties #(
  parameter int unsigned CHECK_CYC    = 20,
  parameter int unsigned RECOVERY_CYC = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic supply_ok_i,
  input wire logic manual_reset_in_n_i,
  input wire logic delay_pin_low_i,
  input wire logic delay_pin_above_th_i,
  input wire logic in_window_i,
  input wire logic ov_detect_i,
  input wire logic uv_detect_i,
  input wire logic reset_o,
  input wire logic check_force_ov_o,
  input wire logic check_force_uv_o,
  input wire logic check_busy_o,
  input wire logic check_fail_o,
  input wire logic latched_o
);
  int bc_r, rc_r;
  always_ff @(posedge clk_i) bc_r <= check_busy_o ? bc_r + 1 : 0;
  always_ff @(posedge clk_i) rc_r <= (reset_o && !check_busy_o && !latched_o) ? rc_r + 1 : 0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_FAIL: assert property (check_fail_o |-> reset_o) else $error("fail");
  AST_BUSY: assert property (check_busy_o |-> reset_o && !latched_o) else $error("busy");
  AST_LATCH: assert property (latched_o |-> reset_o) else $error("latch");
  AST_FORCE: assert property (check_force_ov_o |->
    check_busy_o && !check_force_uv_o) else $error("force");
  AST_FORCE_UV: assert property (check_force_uv_o |->
    check_busy_o && !check_force_ov_o) else $error("force uv");
  AST_MR: assert property (!manual_reset_in_n_i [*5] |=> reset_o) else $error("mr");
  AST_LEN: assert property ($fell(check_busy_o) && $past(resetn_i) |->
    bc_r >= CHECK_CYC - 1 && bc_r <= CHECK_CYC + 1) else $error("length");
  AST_UNLATCH: assert property ((latched_o && manual_reset_in_n_i) [*4] ##1 (latched_o
    && manual_reset_in_n_i && delay_pin_above_th_i) |-> ##[1:4] !reset_o) else $error("unlatch");
  AST_RECOV: assert property ($fell(reset_o) && !$past(latched_o) |->
    rc_r >= RECOVERY_CYC) else $error("recovery");
  AST_ONCE: assert property ((manual_reset_in_n_i && supply_ok_i) [*6] |=>
    !$rose(check_busy_o)) else $error("rerun");
  cover property (latched_o && delay_pin_above_th_i);
  cover property (check_fail_o);
  cover property ($fell(reset_o));
  cover property (latched_o && in_window_i);
endmodule // rlst_seq_properties
bind rlst_seq rlst_seq_properties #(.CHECK_CYC(CHECK_CYC), .RECOVERY_CYC(RECOVERY_CYC))
  u_prop (
  .clk_i                (clk_i),
  .resetn_i             (resetn_i),
  .supply_ok_i          (supply_ok_i),
  .manual_reset_in_n_i  (manual_reset_in_n_i),
  .delay_pin_low_i      (delay_pin_low_i),
  .delay_pin_above_th_i (delay_pin_above_th_i),
  .in_window_i          (in_window_i),
  .ov_detect_i          (ov_detect_i),
  .uv_detect_i          (uv_detect_i),
  .reset_o              (reset_o),
  .check_force_ov_o     (check_force_ov_o),
  .check_force_uv_o     (check_force_uv_o),
  .check_busy_o         (check_busy_o),
  .check_fail_o         (check_fail_o),
  .latched_o            (latched_o)
);

// ### dv/rlst_cmp_model.sv
// rlst_cmp_model: over/undervoltage comparators seen during the check
// assumes force levels from rlst_seq; brk_i makes both stay silent
`timescale 1ns/10ps
module rlst_cmp_model (
  input  wire logic clk_i,
  input  wire logic force_ov_i,
  input  wire logic force_uv_i,
  input  wire logic brk_i,
  output logic      ov_o,
  output logic      uv_o
);
  // registered answer: a slow comparator, not an echo
  always_ff @(posedge clk_i) begin
    ov_o <= force_ov_i && !brk_i;
    uv_o <= force_uv_i && !brk_i;
  end
endmodule // rlst_cmp_model

// ### dv/testbench.sv
// testbench: check, latch, window and failure sequences of rlst_seq
// assumes rlst_pkg and the comparator model are compiled first
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t %h %h", $time, a, e); end end
module testbench;
  localparam int CHK_CYC = 20;
  localparam int RCV_CYC = 4;
  logic clk_i = 0, resetn_i = 0, sup = 0, mr_n = 1, dlo = 0, dth = 0, win = 1, brk = 0;
  logic ov, uv, rst, fov, fuv, busy, fail, lat;
  logic [2:0] q[$], prev = 3'h4, exp_v;
  logic [31:0] lf = 32'h26eb;
  int n_mismatch = 0, comparisons = 0;
  int busy_len = 0;
  always #12.5 clk_i = ~clk_i;
  rlst_seq #(.CHECK_CYC(CHK_CYC), .RECOVERY_CYC(RCV_CYC)) uut (.clk_i, .resetn_i,
    .supply_ok_i(sup),
    .manual_reset_in_n_i(mr_n), .delay_pin_low_i(dlo), .delay_pin_above_th_i(dth),
    .in_window_i(win), .ov_detect_i(ov), .uv_detect_i(uv), .reset_o(rst),
    .check_force_ov_o(fov), .check_force_uv_o(fuv), .check_busy_o(busy),
    .check_fail_o(fail), .latched_o(lat));
  rlst_cmp_model cmp (.clk_i, .force_ov_i(fov), .force_uv_i(fuv), .brk_i(brk), .ov_o(ov),
    .uv_o(uv));
  // every change of rst, fail or lat must be the next noted one; stray changes meet an empty queue
  always @(negedge clk_i) if (resetn_i && {rst, fail, lat} !== prev) begin
    prev = {rst, fail, lat};
    exp_v = q.size() ? q.pop_front() : 3'hx;
    `CHK(prev, exp_v)
  end
  // each check must keep busy up for exactly its length, pass or fail
  always @(negedge clk_i) if (resetn_i) begin
    if (busy === 1'b1) busy_len++;
    else if (busy_len != 0) begin
      `CHK(busy_len, CHK_CYC)
      busy_len = 0;
    end
  end
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task w(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task go(input logic [2:0] e);
    q.push_back(e);
    for (int i = 0; i < 300 && q.size() > 0; i++) @(posedge clk_i);
    // a result that never came ends the run as a failure
    if (q.size() > 0) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task wrap_up;
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    w(5); resetn_i = 1; sup = 1; go(3'h0);
    repeat (16) begin w(1); lf = lfsr(lf); dth = lf[0]; end
    w(1); dth = 0; mr_n = 0; go(3'h4);
    w(1); mr_n = 1; go(3'h0);
    w(1); win = 0; go(3'h4);
    w(1); win = 1; go(3'h0);
    w(1); dlo = 1; mr_n = 0; go(3'h4);
    w(1); mr_n = 1; go(3'h5);
    w(40); dth = 1; go(3'h0);
    w(1); dth = 0; win = 0; go(3'h5);
    w(1); win = 1; w(30); dth = 1; go(3'h0);
    w(1); dth = 0; dlo = 0; brk = 1; mr_n = 0; go(3'h4);
    w(1); mr_n = 1; go(3'h6);
    w(30); sup = 0; go(3'h4);
    w(1); brk = 0; sup = 1; go(3'h0);
    w(20); wrap_up();
  end
endmodule // testbench
